// ---- verilog/tccu_top.sv ----
// Timer capture unit and two compare units behind an AHB-Lite slave
`timescale 1ns/1ps
module tccu_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Prescaled timer tick, same clock domain
	input wire logic timer_tick,
	// External event sources, asynchronous
	input wire logic capture_input_pin,
	input wire logic comparator_output,
	// Interrupt service acknowledges
	input wire logic capture_irq_ack,
	input wire logic compare_a_irq_ack,
	input wire logic compare_b_irq_ack,
	// Interrupt requests and compare outputs
	output logic capture_irq,
	output logic compare_a_irq,
	output logic compare_b_irq,
	output logic compare_output_a,
	output logic compare_output_b
);
	import tccu_pkg::*;

	tccu_state_t r_reg;
	tccu_state_t r_next;
	logic [3:0] mode;
	logic [15:0] top;
	logic pwm;
	logic dual;
	logic icr_top;
	logic ubot;
	logic src;
	logic det_in;
	logic trig;
	logic at_top;
	logic upd;
	logic wcnt;
	logic apsel;
	logic wr_unit;
	logic rd_unit;
	logic [1:0] match;
	logic [1:0] frc;
	logic [2:0] clr;
	logic [2:0] set;
	logic [2:0] ack;
	logic [1:0] com;

	// ********************************
	// Next-state logic
	// ********************************
	always_comb begin
		r_next = r_reg;
		mode = r_reg.ctrl[B_MODE+:4];
		wcnt = 1'b0;
		clr = 3'h0;
		frc = 2'h0;
		set = 3'h0;
		com = 2'h0;
		ack = {compare_b_irq_ack, compare_a_irq_ack, capture_irq_ack};
		// Mode decode: top source, slope, buffering
		unique case (mode)
			4'h1, 4'h5: top = TOP_8;
			4'h2, 4'h6: top = TOP_9;
			4'h3, 4'h7: top = TOP_10;
			4'h4, 4'h9, 4'hB, 4'hF: top = r_reg.ocr[0];
			4'h8, 4'hA, 4'hC, 4'hE: top = r_reg.cap;
			default: top = TOP_MAX;
		endcase
		icr_top = mode inside {4'h8, 4'hA, 4'hC, 4'hE};
		dual = mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
		pwm = !(mode inside {4'h0, 4'h4, 4'hC, 4'hD});
		ubot = mode inside {4'h8, 4'h9};

		// Two-flop synchronisers for both event sources
		r_next.sync1 = {comparator_output, capture_input_pin};
		r_next.sync2 = r_reg.sync1;
		// Source select, software port drive overrides pin
		if (r_reg.ctrl[B_CSEL]) begin
			src = r_reg.sync2[1];
		end else if (r_reg.ctrl[B_PDRV]) begin
			src = r_reg.ctrl[B_PLVL];
		end else begin
			src = r_reg.sync2[0];
		end
		// Noise filter runs on every system clock
		r_next.filt_sh = {r_reg.filt_sh[FILT_LEN-2:0], src};
		if (&r_next.filt_sh) begin
			r_next.filt_out = 1'b1;
		end else if (~|r_next.filt_sh) begin
			r_next.filt_out = 1'b0;
		end
		// Filter sits in front of the edge detector
		det_in = r_reg.ctrl[B_FILT] ? r_reg.filt_out : src;
		r_next.edge_prev = det_in;
		trig = !icr_top && (det_in != r_reg.edge_prev)
			&& (det_in == r_reg.ctrl[B_EDGE]);
		if (trig) begin
			r_next.cap = r_reg.cnt;
			set[F_CAP] = 1'b1;
		end

		// Bus address phase: reads answer from here
		apsel = hsel && htrans[1] && hready;
		// Compare unit picked by the pending write and by this read
		wr_unit = r_reg.a_addr inside {OFS_CMPB_L, OFS_CMPB_H};
		rd_unit = haddr[7:0] inside {OFS_CMPB_L, OFS_CMPB_H};
		r_next.a_wr = apsel && hwrite;
		if (apsel) begin
			r_next.a_addr = haddr[7:0];
		end
		r_next.rdata = 32'h0;

		// Data phase of a write
		if (r_reg.a_wr) begin
			unique case (r_reg.a_addr)
				OFS_CTRL: r_next.ctrl = hwdata[15:0];
				OFS_STAT: clr = hwdata[2:0];
				OFS_FORCE: frc = hwdata[1:0];
				OFS_CNT_H, OFS_CAP_H, OFS_CMPA_H, OFS_CMPB_H: begin
					r_next.temp = hwdata[7:0];
				end
				OFS_CNT_L: wcnt = 1'b1;
				OFS_CAP_L: begin
					if (icr_top) begin
						r_next.cap = {r_reg.temp, hwdata[7:0]};
					end
				end
				OFS_CMPA_L, OFS_CMPB_L: begin
					// Buffered in PWM modes, direct otherwise
					if (pwm) begin
						r_next.bufr[wr_unit] =
							{r_reg.temp, hwdata[7:0]};
					end else begin
						r_next.ocr[wr_unit] =
							{r_reg.temp, hwdata[7:0]};
						r_next.bufr[wr_unit] =
							{r_reg.temp, hwdata[7:0]};
					end
				end
				default: ;
			endcase
		end

		// Read data for the coming data phase
		if (apsel && !hwrite) begin
			unique case (haddr[7:0])
				OFS_CTRL: r_next.rdata = {16'h0, r_reg.ctrl};
				OFS_STAT: r_next.rdata = {27'h0, r_reg.oc, r_reg.flags};
				OFS_CNT_L: begin
					r_next.rdata = {24'h0, r_reg.cnt[7:0]};
					r_next.temp = r_reg.cnt[15:8];
				end
				OFS_CAP_L: begin
					r_next.rdata = {24'h0, r_reg.cap[7:0]};
					r_next.temp = r_reg.cap[15:8];
				end
				OFS_CNT_H, OFS_CAP_H: begin
					r_next.rdata = {24'h0, r_reg.temp};
				end
				OFS_CMPA_L, OFS_CMPB_L: begin
					r_next.rdata = {24'h0, pwm ?
						r_reg.bufr[rd_unit][7:0] :
						r_reg.ocr[rd_unit][7:0]};
				end
				OFS_CMPA_H, OFS_CMPB_H: begin
					r_next.rdata = {24'h0, pwm ?
						r_reg.bufr[rd_unit][15:8] :
						r_reg.ocr[rd_unit][15:8]};
				end
				default: ;
			endcase
		end

		// Comparators, gated one tick after a counter write
		for (int i = 0; i < 2; i++) begin
			match[i] = (r_reg.cnt == r_reg.ocr[i]) && !r_reg.blk;
		end
		at_top = (r_reg.cnt == top) && !r_reg.blk;
		upd = pwm && (ubot ? (r_reg.cnt == 16'h0000) : at_top);

		// Counter advance, update points and match effects
		if (timer_tick) begin
			r_next.blk = 1'b0;
			if (dual) begin
				if (r_reg.dir) begin
					r_next.dir = r_reg.cnt == 16'h0001;
					r_next.cnt = r_reg.cnt - 16'h0001;
				end else if (at_top) begin
					r_next.dir = 1'b1;
					r_next.cnt = r_reg.cnt - 16'h0001;
				end else begin
					r_next.cnt = r_reg.cnt + 16'h0001;
				end
			end else if (at_top) begin
				r_next.cnt = 16'h0000;
			end else begin
				r_next.cnt = r_reg.cnt + 16'h0001;
			end
			if (upd) begin
				r_next.ocr = r_reg.bufr;
			end
			set[2:1] = match;
		end
		// Counter write beats counting and arms the block
		if (wcnt) begin
			r_next.cnt = {r_reg.temp, hwdata[7:0]};
			r_next.blk = 1'b1;
			r_next.dir = 1'b0;
		end

		// Output state per unit, action bits used live
		for (int i = 0; i < 2; i++) begin
			com = r_reg.ctrl[B_COMA+2*i+:2];
			if (!pwm) begin
				if ((timer_tick && match[i]) || frc[i]) begin
					unique case (com)
						COM_TGL: r_next.oc[i] = !r_reg.oc[i];
						COM_CLR: r_next.oc[i] = 1'b0;
						COM_SET: r_next.oc[i] = 1'b1;
						default: ;
					endcase
				end
			end else if (dual) begin
				if (timer_tick && match[i] && com[1]) begin
					r_next.oc[i] = com[0] ^ r_reg.dir;
				end
			end else if (com[1] && timer_tick) begin
				if (match[i]) begin
					r_next.oc[i] = !com[0];
				end
				if (at_top) begin
					r_next.oc[i] = com[0];
				end
			end
		end

		// Flags: hardware set wins over any clear
		for (int k = 0; k < 3; k++) begin
			r_next.flags[k] = set[k] ||
				(r_reg.flags[k] && !clr[k] && !ack[k]);
		end
		r_next.irq = r_next.flags & r_reg.ctrl[B_IEC+:3];
		r_next.rdy = 1'b1;
		r_next.resp = 1'b0;
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= ST_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state register
	assign hreadyout = r_reg.rdy;
	assign hresp = r_reg.resp;
	assign hrdata = r_reg.rdata;
	assign capture_irq = r_reg.irq[F_CAP];
	assign compare_a_irq = r_reg.irq[F_CMPA];
	assign compare_b_irq = r_reg.irq[F_CMPB];
	assign compare_output_a = r_reg.oc[0];
	assign compare_output_b = r_reg.oc[1];

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_cmp_src;
		r_reg.ctrl[B_CSEL] && !r_reg.ctrl[B_FILT] && !icr_top
		&& r_reg.sync2[1] != r_reg.edge_prev
		&& r_reg.sync2[1] == r_reg.ctrl[B_EDGE] |=> r_reg.flags[F_CAP];
	endproperty
	a_cmp_src: assert property (p_cmp_src)
		else $error("comparator edge missed");
	property p_cap;
		trig |=> r_reg.cap == $past(r_reg.cnt) && r_reg.flags[F_CAP];
	endproperty
	a_cap: assert property (p_cap)
		else $error("capture value or flag wrong");
	property p_filt;
		$rose(r_reg.filt_out) |-> $past(src, 1) && $past(src, 2)
			&& $past(src, 3) && $past(src, 4);
	endproperty
	a_filt: assert property (p_filt)
		else $error("filter changed early");
	property p_icr_off;
		icr_top && !(r_reg.a_wr && r_reg.a_addr == OFS_CAP_L)
		|=> $stable(r_reg.cap);
	endproperty
	a_icr_off: assert property (p_icr_off)
		else $error("capture in capture-top mode");
	property p_match;
		timer_tick && match[0] |=> r_reg.flags[F_CMPA];
	endproperty
	a_match: assert property (p_match)
		else $error("match flag missing");
	property p_arm;
		wcnt |=> r_reg.blk;
	endproperty
	a_arm: assert property (p_arm)
		else $error("counter write did not arm the block");
	property p_block;
		r_reg.blk && timer_tick
		|=> !$rose(r_reg.flags[F_CMPA]) && !$rose(r_reg.flags[F_CMPB]);
	endproperty
	a_block: assert property (p_block)
		else $error("match after counter write");
	property p_buf;
		pwm && !(timer_tick && upd) |=> $stable(r_reg.ocr);
	endproperty
	a_buf: assert property (p_buf)
		else $error("active compare changed off update");
	property p_load;
		!pwm && r_reg.a_wr && r_reg.a_addr == OFS_CMPA_L
		|=> r_reg.ocr[0] == {$past(r_reg.temp), $past(hwdata[7:0])};
	endproperty
	a_load: assert property (p_load)
		else $error("compare load wrong");
	property p_hi_rd;
		apsel && !hwrite && !pwm && haddr[7:0] == OFS_CMPA_H
		|=> hrdata[7:0] == $past(r_reg.ocr[0][15:8]);
	endproperty
	a_hi_rd: assert property (p_hi_rd)
		else $error("compare high read via latch");
	property p_noact;
		r_reg.ctrl[B_COMA+:2] == COM_NONE |=> $stable(compare_output_a);
	endproperty
	a_noact: assert property (p_noact)
		else $error("output moved with no action");
	property p_ack;
		compare_a_irq_ack && !set[F_CMPA] |=> !r_reg.flags[F_CMPA];
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack did not clear flag");
	property p_force;
		frc[0] && !pwm && !(timer_tick && match[0]) && !r_reg.flags[F_CMPA]
		|=> !r_reg.flags[F_CMPA];
	endproperty
	a_force: assert property (p_force)
		else $error("force set the flag");
	c_cap: cover property (trig);
	c_match: cover property (timer_tick && match[1]);
	c_force: cover property (frc[0] && !pwm);
	c_filt: cover property (r_reg.ctrl[B_FILT] && trig);
endmodule

// ---- verilog/tccu_pkg.sv ----
// Constants and state type of the timer capture/compare block
package tccu_pkg;
	// ********************************
	// Register offsets (byte addresses)
	// ********************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_FORCE = 8'h08;
	localparam logic [7:0] OFS_CNT_L = 8'h0C;
	localparam logic [7:0] OFS_CNT_H = 8'h10;
	localparam logic [7:0] OFS_CAP_L = 8'h14;
	localparam logic [7:0] OFS_CAP_H = 8'h18;
	localparam logic [7:0] OFS_CMPA_L = 8'h1C;
	localparam logic [7:0] OFS_CMPA_H = 8'h20;
	localparam logic [7:0] OFS_CMPB_L = 8'h24;
	localparam logic [7:0] OFS_CMPB_H = 8'h28;
	// ********************************
	// Control field positions
	// ********************************
	localparam int B_MODE = 0;
	localparam int B_COMA = 4;
	localparam int B_COMB = 6;
	localparam int B_EDGE = 8;
	localparam int B_FILT = 9;
	localparam int B_CSEL = 10;
	localparam int B_PDRV = 11;
	localparam int B_PLVL = 12;
	localparam int B_IEC = 13;
	localparam int B_IEA = 14;
	// Flag positions in the status word
	localparam int F_CAP = 0;
	localparam int F_CMPA = 1;
	localparam int F_CMPB = 2;
	// Filter sample count
	localparam int FILT_LEN = 4;
	// Fixed counter tops
	localparam logic [15:0] TOP_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8 = 16'h00FF;
	localparam logic [15:0] TOP_9 = 16'h01FF;
	localparam logic [15:0] TOP_10 = 16'h03FF;
	// Output action codes
	localparam logic [1:0] COM_NONE = 2'h0;
	localparam logic [1:0] COM_TGL = 2'h1;
	localparam logic [1:0] COM_CLR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	// ********************************
	// Block state
	// ********************************
	typedef struct packed {
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [FILT_LEN-1:0] filt_sh;
		logic filt_out;
		logic edge_prev;
		logic dir;
		logic blk;
		logic [15:0] cnt;
		logic [15:0] cap;
		logic [15:0] ctrl;
		logic [1:0][15:0] ocr;
		logic [1:0][15:0] bufr;
		logic [7:0] temp;
		logic [7:0] a_addr;
		logic a_wr;
		logic rdy;
		logic resp;
		logic [2:0] flags;
		logic [2:0] irq;
		logic [1:0] oc;
		logic [31:0] rdata;
	} tccu_state_t;
	localparam tccu_state_t ST_RST = '{rdy: 1'b1, default: '0};
endpackage

// ---- dv/tccu_evt_src.sv ----
// Model of the external event source and the comparator
`timescale 1ns/1ps
module tccu_evt_src (
	// Levels requested by the bench
	pin_req,
	cmp_req,
	// Asynchronous event lines
	capture_input_pin,
	comparator_output
);
	input wire logic pin_req;
	input wire logic cmp_req;
	output logic capture_input_pin;
	output logic comparator_output;
	// ****************
	// Event lines
	// ****************
	// Lines move 2 ns after the request, off the sampling edge
	assign #2 capture_input_pin = pin_req;
	assign #2 comparator_output = cmp_req;
endmodule

// ---- dv/tccu_top_tb.sv ----
// Self-checking bench of the timer capture/compare block
`timescale 1ns/1ps
module tccu_top_tb;
	import tccu_pkg::*;
	// ****************
	// Signals
	// ****************
	localparam logic [31:0] CB = (32'h1 << B_EDGE) | (32'h1 << B_IEC);
	localparam logic [31:0] IEA = 32'h1 << B_IEA;
	localparam logic [31:0] TGA = 32'(COM_TGL) << B_COMA;
	localparam logic [31:0] TGB = 32'(COM_TGL) << B_COMB;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic timer_tick, pin_req, cmp_req, pin, cmp;
	logic cap_ack, a_ack, b_ack, capture_irq, compare_a_irq;
	logic out_a, out_b, irq_b;
	int n_errors = 0;
	int checks = 0;
	assign hready = hreadyout;
	tccu_evt_src tccu_evt_src_i (.pin_req(pin_req), .cmp_req(cmp_req),
		.capture_input_pin(pin), .comparator_output(cmp));
	tccu_top tccu_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .timer_tick(timer_tick),
		.capture_input_pin(pin), .comparator_output(cmp),
		.capture_irq_ack(cap_ack), .compare_a_irq_ack(a_ack),
		.compare_b_irq_ack(b_ack), .capture_irq(capture_irq),
		.compare_a_irq(compare_a_irq), .compare_b_irq(irq_b),
		.compare_output_a(out_a), .compare_output_b(out_b));
	// Clock of 8 ns
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	// Compares a value and counts mismatches
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		checks++;
		if (seen !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, seen);
		end
	endtask
	// One AHB single transfer, waits on hready in both phases
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask
	// Write, then one idle cycle so a read back sees the new value
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		@(posedge hclk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk("register read", r, e);
	endtask
	// One timer clock, then one quiet cycle
	task tk();
		timer_tick <= 1'b1;
		@(posedge hclk);
		timer_tick <= 1'b0;
		@(posedge hclk);
	endtask
	// Raises one source, counts edges until the capture irq shows
	task trig(input int src, input logic [31:0] e);
		logic [31:0] n;
		n = 32'h0;
		if (src == 0) pin_req <= 1'b1;
		else cmp_req <= 1'b1;
		while (capture_irq !== 1'b1 && n < 32'h14) begin
			@(posedge hclk);
			n = n + 32'h1;
		end
		chk("capture latency", n, e);
		pin_req <= 1'b0;
		cmp_req <= 1'b0;
		repeat (12) @(posedge hclk);
		wr(OFS_STAT, 32'h1);
		repeat (2) @(posedge hclk);
	endtask
	task complete_run();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#100000;
		n_errors++;
		complete_run();
	end
	// ****************
	// Test sequence
	// ****************
	initial begin
		{hresetn, hwrite, timer_tick, pin_req, cmp_req} = 5'h00;
		{cap_ack, a_ack, b_ack} = 3'h0;
		hsel = 1'b1;
		hsize = 3'h2;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(OFS_CTRL, 32'h0);
		rd(OFS_STAT, 32'h0);
		wr(OFS_CTRL, CB);
		wr(OFS_CNT_H, 32'h12);
		wr(OFS_CNT_L, 32'h34);
		trig(0, 32'h4);
		rd(OFS_CAP_L, 32'h34);
		rd(OFS_CAP_H, 32'h12);
		trig(1, 32'h14);
		wr(OFS_CTRL, CB | (32'h1 << B_CSEL));
		trig(0, 32'h14);
		wr(OFS_CNT_L, 32'h77);
		wr(OFS_CNT_H, 32'h0);
		wr(OFS_CNT_L, 32'h77);
		trig(1, 32'h4);
		rd(OFS_CAP_L, 32'h77);
		rd(OFS_CAP_H, 32'h0);
		wr(OFS_CTRL, CB | (32'h1 << B_FILT));
		trig(0, 32'h8);
		pin_req <= 1'b1;
		repeat (3) @(posedge hclk);
		pin_req <= 1'b0;
		repeat (12) @(posedge hclk);
		rd(OFS_STAT, 32'h0);
		wr(OFS_CTRL, 32'h1 << B_IEC);
		trig(0, 32'h14);
		wr(OFS_CTRL, CB | (32'h1 << B_PDRV));
		wr(OFS_CTRL, CB | (32'h3 << B_PDRV));
		repeat (6) @(posedge hclk);
		rd(OFS_STAT, 32'h1);
		wr(OFS_STAT, 32'h1);
		wr(OFS_CTRL, CB | 32'hC);
		trig(0, 32'h14);
		// Compare unit A, toggle on match
		wr(OFS_CTRL, TGA | IEA);
		wr(OFS_CMPA_H, 32'h3);
		wr(OFS_CMPA_L, 32'h5);
		rd(OFS_CAP_L, 32'h77);
		rd(OFS_CMPA_H, 32'h3);
		rd(OFS_CMPA_L, 32'h5);
		wr(OFS_CNT_H, 32'h3);
		wr(OFS_CNT_L, 32'h4);
		tk();
		tk();
		chk("output a", {31'h0, out_a}, 32'h1);
		chk("irq a", {31'h0, compare_a_irq}, 32'h1);
		chk("irq b", {31'h0, irq_b}, 32'h0);
		@(posedge hclk);
		chk("irq a", {31'h0, compare_a_irq}, 32'h1);
		a_ack <= 1'b1;
		@(posedge hclk);
		a_ack <= 1'b0;
		@(posedge hclk);
		rd(OFS_STAT, 32'h8);
		wr(OFS_CNT_L, 32'h5);
		tk();
		rd(OFS_STAT, 32'h8);
		wr(OFS_FORCE, 32'h1);
		rd(OFS_STAT, 32'h0);
		wr(OFS_CTRL, IEA);
		wr(OFS_CNT_L, 32'h4);
		tk();
		tk();
		rd(OFS_STAT, 32'h2);
		wr(OFS_STAT, 32'h2);
		// Buffered compare B in fast PWM, 8-bit top
		wr(OFS_CTRL, 32'h5);
		wr(OFS_CNT_H, 32'h0);
		wr(OFS_CNT_L, 32'h20);
		wr(OFS_CMPB_H, 32'h0);
		wr(OFS_CMPB_L, 32'h21);
		rd(OFS_CMPB_L, 32'h21);
		tk();
		tk();
		rd(OFS_STAT, 32'h0);
		wr(OFS_CNT_L, 32'hFE);
		tk();
		tk();
		wr(OFS_CNT_L, 32'h20);
		tk();
		tk();
		rd(OFS_STAT, 32'h4);
		// Compare A as top in clear-on-match, then variable-top fast PWM
		wr(OFS_CTRL, 32'h4 | TGA | TGB);
		wr(OFS_CMPA_H, 32'h0);
		wr(OFS_CMPA_L, 32'h30);
		wr(OFS_CNT_L, 32'h2F);
		tk();
		tk();
		rd(OFS_CNT_L, 32'h0);
		wr(OFS_FORCE, 32'h2);
		chk("output b", {31'h0, out_b}, 32'h1);
		wr(OFS_CTRL, 32'hF);
		wr(OFS_CNT_L, 32'h30);
		tk();
		tk();
		rd(OFS_CNT_L, 32'h32);
		rd(OFS_STAT, 32'h1E);
		wr(OFS_CTRL, 32'hF | (IEA << 1));
		@(posedge hclk);
		chk("irq b", {31'h0, irq_b}, 32'h1);
		complete_run();
	end
endmodule
